// ---- shared/fba_pkg.sv ----
// fba_pkg: register map, field layout and reset image of the four-master bus arbiter
// assumes: one bus clock, classic 32-bit wishbone register port, masters on the same clock

package fba_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADR_CTL = 8'h00; // arbiter_park_control
    localparam logic [7:0] ADR_STAT = 8'h04; // read-only arbiter state

    // ****************************************************************
    // control field positions
    // ****************************************************************
    localparam int BOOST_BIT = 25; // dma_bandwidth_boost_enable
    localparam int P3_LSB = 22; // master_three_priority
    localparam int P2_LSB = 20; // master_two_priority
    localparam int P0_LSB = 18; // master_zero_priority
    localparam int P1_LSB = 16; // master_one_priority
    localparam int FIXED_BIT = 14; // zero rotating, one fixed
    localparam int TMO_BIT = 13; // starvation count enable
    localparam int PARK_BIT = 12; // park_on_top_priority
    localparam int EXP_LSB = 8; // starvation_limit_exponent, four bits

    // writable bits; reserved bits stay zero
    localparam logic [31:0] CTL_WR_MASK = 32'h02FF_7F00;
    // reset image: rotating, priorities 3 > 2 > 1 > 0
    localparam logic [31:0] CTL_RESET = 32'h00E1_0000;

    // ****************************************************************
    // priorities and masters
    // ****************************************************************
    // packed per master index, two bits each, master 3 in the top pair
    localparam logic [7:0] PRIO_DEFAULT = 8'hE4;
    localparam logic [1:0] DMA_IDX = 2'h2; // dma_master_port
    localparam int CNT_W = 16; // holds two to the fifteenth

    // status word layout
    localparam int ST_PTR_LSB = 0;
    localparam int ST_OWN_LSB = 2;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_DUP_BIT = 6;
    localparam int ST_HIT_LSB = 8;

    // ****************************************************************
    // arbitration mode, gray along rotate -> fixed -> starved
    // ****************************************************************
    typedef enum logic [1:0] {
        FBA_ROT = 2'h0,
        FBA_FIX = 2'h1,
        FBA_STARVE = 2'h3
    } fba_mode_e;

endpackage : fba_pkg

// ---- design/fba_starve_cnt.sv ----
// fba_starve_cnt: one master's lockout counter with power-of-two limit
// assumes: inc and clr come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module fba_starve_cnt (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic en,
    input wire logic inc,
    input wire logic clr,
    input wire logic [3:0] limit_exp,
    // status
    output logic hit
);

    // ****************************************************************
    // counter
    // ****************************************************************
    logic [fba_pkg::CNT_W-1:0] cnt_r; // denied cycles so far
    logic [fba_pkg::CNT_W-1:0] cnt_nxt;
    logic hit_r; // count has reached the limit
    wire [fba_pkg::CNT_W-1:0] limit = 16'h0001 << limit_exp;
    wire at_limit = (cnt_r >= limit);

    // saturate at the limit so a long lockout cannot wrap back to zero
    assign cnt_nxt = (!en || clr) ? '0
                   : ((inc && !at_limit) ? cnt_r + 16'h0001 : cnt_r);

    // count register and registered hit flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            hit_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_r <= (cnt_nxt >= limit);
        end
    end

    assign hit = hit_r;

endmodule : fba_starve_cnt

`default_nettype wire

// ---- design/fba_arbiter.sv ----
// fba_arbiter: four-master pipelined bus arbiter with wishbone control register
// assumes: master requests, bus-free and busy flags come from logic on clk
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module fba_arbiter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // master side
    input wire logic [3:0] mst_req,
    input wire logic addr_phase_free,
    input wire logic owner_busy,
    input wire logic xfer_done,
    input wire logic dma_boost_req,
    // arbitration results
    output logic [1:0] arb_ptr,
    output logic [1:0] bus_owner,
    output logic starve_active
);

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // index of the candidate with the largest effective priority
    function automatic logic [1:0] pick_top(input logic [3:0] cand, input logic [7:0] eff);
        logic [1:0] best;
        logic [1:0] best_eff;
        logic found;
        best = 2'h0;
        best_eff = 2'h0;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (cand[i] && (!found || eff[2*i +: 2] > best_eff)) begin
                best = 2'(i);
                best_eff = eff[2*i +: 2];
                found = 1'b1;
            end
        end
        return best;
    endfunction : pick_top

    // one-hot mask of a master index
    function automatic logic [3:0] one_hot(input logic [1:0] idx);
        return 4'h1 << idx;
    endfunction : one_hot

    // true when the four priority pairs are all different
    function automatic logic all_distinct(input logic [7:0] p);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int j = i + 1; j < 4; j++) begin
                if (p[2*i +: 2] == p[2*j +: 2]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction : all_distinct

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0] ctl_r; // arbiter_park_control
    logic [31:0] ctl_nxt;
    logic [31:0] dat_r; // registered read data
    logic ack_r; // single-cycle wishbone ack
    logic [1:0] ptr_r; // arbitration pointer
    logic [1:0] ptr_nxt;
    logic [1:0] owner_r; // current bus owner, also last active master
    logic [1:0] owner_nxt;
    fba_pkg::fba_mode_e mode_r; // effective arbitration mode
    fba_pkg::fba_mode_e mode_nxt;
    logic [3:0] hit; // per-master lockout reached

    // ****************************************************************
    // control field decode
    // ****************************************************************
    wire ctl_fixed = ctl_r[fba_pkg::FIXED_BIT];
    wire ctl_tmo = ctl_r[fba_pkg::TMO_BIT];
    wire ctl_park_top = ctl_r[fba_pkg::PARK_BIT];
    wire ctl_boost = ctl_r[fba_pkg::BOOST_BIT];
    wire [3:0] ctl_exp = ctl_r[fba_pkg::EXP_LSB +: 4];
    // packed by master index: pair i belongs to master i
    wire [7:0] prio_raw = {ctl_r[fba_pkg::P3_LSB +: 2], ctl_r[fba_pkg::P2_LSB +: 2],
                           ctl_r[fba_pkg::P1_LSB +: 2], ctl_r[fba_pkg::P0_LSB +: 2]};
    wire prio_ok = all_distinct(prio_raw);
    // software owes us distinct values; if not, the initial order rules
    wire [7:0] prio = prio_ok ? prio_raw : fba_pkg::PRIO_DEFAULT;

    // ****************************************************************
    // effective priorities
    // ****************************************************************
    wire [7:0] eff_rot; // rotated priorities, wrapping two-bit sum
    wire [1:0] owner_prio = prio[2*owner_r +: 2];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rot
            // two-bit add wraps, giving the modulo-four sum
            assign eff_rot[2*gi +: 2] = prio[2*gi +: 2] + owner_prio;
        end
    endgenerate

    // ****************************************************************
    // candidate selection
    // ****************************************************************
    // pointed requester takes the free address phase with no delay
    wire immediate = mst_req[ptr_r] && addr_phase_free;
    wire [3:0] granted = immediate ? one_hot(ptr_r) : 4'h0;
    // the immediate winner is left out; the rest decide the next pointer
    wire [3:0] cand = mst_req & ~granted;
    wire rotating = (mode_r != fba_pkg::FBA_FIX);
    // outside fixed mode, a master that just finished drops below everybody else
    wire [3:0] cand_rr_x = cand & ~one_hot(owner_r);
    wire drop_owner = rotating && xfer_done && (cand_rr_x != 4'h0);
    wire [3:0] cand_eval = drop_owner ? cand_rr_x : cand;
    wire [1:0] pick_rot = pick_top(cand_eval, eff_rot);
    wire [1:0] pick_fix = pick_top(cand_eval, prio);
    // winner of the selected algorithm, before hold and boost override it
    wire [1:0] pick_alg = rotating ? pick_rot : pick_fix;
    wire [1:0] pick_park = pick_top(4'hF, prio);
    // elevation from the dma engine counts only while enabled
    wire boost_act = ctl_boost && dma_boost_req && cand[fba_pkg::DMA_IDX];
    // fixed winner keeps the bus while its transfers are still open
    wire hold = (mode_r == fba_pkg::FBA_FIX) && owner_busy;
    wire any_hit = (hit != 4'h0);

    // ****************************************************************
    // next pointer: hold, boost, algorithm, keep, park
    // ****************************************************************
    always_comb begin
        ptr_nxt = ptr_r;
        if (hold) begin
            // pointer follows the owner of this cycle; pointing at the old
            // owner would hand the bus back and forth every cycle
            ptr_nxt = owner_nxt;
        end else if (boost_act) begin
            // boosted dma wins the next decision
            ptr_nxt = fba_pkg::DMA_IDX;
        end else if (cand_eval != 4'h0) begin
            // mode picks the algorithm
            ptr_nxt = pick_alg;
        end else if (immediate) begin
            // only the winner requests; pointer stays on it
            ptr_nxt = ptr_r;
        end else begin
            // nobody requests: park on top or on the last owner
            ptr_nxt = ctl_park_top ? pick_park : owner_r;
        end
    end

    // owner follows the immediate winner
    assign owner_nxt = immediate ? ptr_r : owner_r;

    // ****************************************************************
    // mode state machine
    // ****************************************************************
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            fba_pkg::FBA_ROT: begin
                // leave rotating only when fixed is selected
                if (ctl_fixed) begin
                    mode_nxt = fba_pkg::FBA_FIX;
                end
            end
            fba_pkg::FBA_FIX: begin
                if (!ctl_fixed) begin
                    mode_nxt = fba_pkg::FBA_ROT;
                end else if (ctl_tmo && any_hit) begin
                    // a locked-out master forces rotation
                    mode_nxt = fba_pkg::FBA_STARVE;
                end
            end
            fba_pkg::FBA_STARVE: begin
                if (!ctl_fixed) begin
                    mode_nxt = fba_pkg::FBA_ROT;
                end else if (!ctl_tmo || !any_hit) begin
                    // all locks cleared or counting disabled: back to fixed priority
                    mode_nxt = fba_pkg::FBA_FIX;
                end
            end
            default: begin
                // unused code: recover into rotating
                mode_nxt = fba_pkg::FBA_ROT;
            end
        endcase
    end

    // ****************************************************************
    // starvation counters
    // ****************************************************************
    // counters only run in fixed mode with counting enabled
    wire cnt_en = ctl_fixed && ctl_tmo;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cnt
            fba_starve_cnt u_cnt (
                .clk(clk),
                .rst(rst),
                .en(cnt_en),
                .inc(mst_req[gi] && !granted[gi]),
                .clr(!mst_req[gi] || granted[gi]),
                .limit_exp(ctl_exp),
                .hit(hit[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // arbitration registers
    // ****************************************************************
    // reset lands in rotating mode, pointer and owner on master 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_r <= 2'h0;
            owner_r <= 2'h0;
            mode_r <= fba_pkg::FBA_ROT;
        end else begin
            ptr_r <= ptr_nxt;
            owner_r <= owner_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ****************************************************************
    // wishbone register port
    // ****************************************************************
    wire wb_req = wb_cyc_i && wb_stb_i;
    wire sel_ctl = (wb_adr_i == fba_pkg::ADR_CTL);
    wire sel_stat = (wb_adr_i == fba_pkg::ADR_STAT);
    // write takes effect at the edge where ack is seen high
    wire wr_ctl = wb_req && wb_we_i && ack_r && sel_ctl;
    wire [31:0] be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wr_mask = be_mask & fba_pkg::CTL_WR_MASK;
    wire [31:0] stat_word = {20'h0_0000, hit, 1'b0, ~prio_ok, mode_r, owner_r, ptr_r};
    // unmapped addresses read zero and still get an ack
    wire [31:0] rd_mux = sel_ctl ? ctl_r : (sel_stat ? stat_word : 32'h0000_0000);

    assign ctl_nxt = wr_ctl ? ((ctl_r & ~wr_mask) | (wb_dat_i & wr_mask)) : ctl_r;

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            ctl_r <= fba_pkg::CTL_RESET;
        end else begin
            ack_r <= wb_req && !ack_r;
            dat_r <= (wb_req && !ack_r) ? rd_mux : dat_r;
            ctl_r <= ctl_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign arb_ptr = ptr_r;
    assign bus_owner = owner_r;
    // status bit straight from the mode register
    assign starve_active = mode_r[1];

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_owner_takes:
    assert property (@(posedge clk) disable iff (rst)
        immediate |=> (owner_r == $past(ptr_r)))
    else $error("immediate winner did not become owner");

    a_fixed_hold:
    assert property (@(posedge clk) disable iff (rst)
        hold |=> (ptr_r == owner_r))
    else $error("fixed owner lost pointer while busy");

    a_dma_boost:
    assert property (@(posedge clk) disable iff (rst)
        (boost_act && !hold) |=> (ptr_r == fba_pkg::DMA_IDX))
    else $error("boosted dma did not win");

    a_boost_off:
    assert property (@(posedge clk) disable iff (rst)
        (!ctl_boost && dma_boost_req && !hold && cand_eval != 4'h0) |=> (ptr_r == $past(pick_alg)))
    else $error("boost acted while disabled");

    a_park_top:
    assert property (@(posedge clk) disable iff (rst)
        (mst_req == 4'h0 && !hold && ctl_park_top) |=> (ptr_r == $past(pick_park)))
    else $error("idle pointer not parked on top master");

    a_park_last:
    assert property (@(posedge clk) disable iff (rst)
        (mst_req == 4'h0 && !ctl_park_top) |=> (ptr_r == $past(owner_r)))
    else $error("idle pointer left last owner");

    a_rot_no_starve:
    assert property (@(posedge clk) disable iff (rst)
        !ctl_fixed |=> (mode_r == fba_pkg::FBA_ROT) && (hit == 4'h0))
    else $error("starvation logic active in rotating mode");

    a_starve_enter:
    assert property (@(posedge clk) disable iff (rst)
        (mode_r == fba_pkg::FBA_FIX && ctl_fixed && ctl_tmo && any_hit) |=> starve_active)
    else $error("lockout did not force rotation");

    a_dup_default:
    assert property (@(posedge clk) disable iff (rst)
        !prio_ok |-> (prio == fba_pkg::PRIO_DEFAULT))
    else $error("duplicate priorities used as programmed");

    a_ack_single:
    assert property (@(posedge clk) disable iff (rst)
        ack_r |=> !ack_r)
    else $error("ack held more than one cycle");

    a_owner_stays:
    assert property (@(posedge clk) disable iff (rst)
        !immediate |=> (owner_r == $past(owner_r)))
    else $error("owner changed without an immediate grant");

    a_drop_owner:
    assert property (@(posedge clk) disable iff (rst)
        (drop_owner && !boost_act) |=> (ptr_r != $past(owner_r)))
    else $error("finished owner kept the pointer");

    a_starve_leave:
    assert property (@(posedge clk) disable iff (rst)
        (mode_r == fba_pkg::FBA_STARVE && ctl_fixed && !any_hit) |=> (mode_r == fba_pkg::FBA_FIX))
    else $error("cleared lockout did not return to fixed mode");

endmodule : fba_arbiter

`default_nettype wire

// ---- verif/fba_masters.sv ----
// fba_masters: far-side model of the four bus masters and the bus fabric
// assumes: the bench sets the request levels; shares clk and rst with the arbiter
`timescale 1ns/1ns
`default_nettype none

module fba_masters (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench controls
    input wire logic [3:0] req_lvl,
    input wire logic free_lvl,
    input wire logic busy_lvl,
    input wire logic boost_lvl,
    // arbiter side
    output logic [3:0] mst_req,
    output logic addr_phase_free,
    output logic owner_busy,
    output logic xfer_done,
    output logic dma_boost_req
);
    // ****************************************************************
    // master behaviour
    // ****************************************************************
    logic busy_d_r; // owner busy one cycle ago

    // requests are held as levels until the bench drops them
    assign mst_req = req_lvl;
    assign addr_phase_free = free_lvl;
    assign owner_busy = busy_lvl;
    assign dma_boost_req = boost_lvl;

    // completion pulse once the owner closes its last open transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_d_r <= 1'b0;
            xfer_done <= 1'b0;
        end else begin
            busy_d_r <= busy_lvl;
            xfer_done <= busy_d_r & ~busy_lvl;
        end
    end
endmodule : fba_masters
`default_nettype wire

// ---- verif/fba_arbiter_bench.sv ----
// fba_arbiter_bench: self-checking bench for the four-master arbiter
// assumes: fba_pkg and the design compiled first; masters modelled by fba_masters
`timescale 1ns/1ns
`default_nettype none

module fba_arbiter_bench;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic clk = 1'b0; // 100 MHz bus clock
    logic rst = 1'b1; // held for five cycles
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack;
    logic [3:0] req_lvl = 4'h0; // requests wanted by the bench
    logic busy_lvl = 1'b0;
    logic free_lvl = 1'b1; // address phase available
    logic boost_lvl = 1'b0;
    logic [3:0] mst_req;
    logic free;
    logic busy;
    logic done;
    logic boost;
    logic [1:0] ptr;
    logic [1:0] owner;
    logic starve;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    fba_masters mst_u (.clk(clk), .rst(rst), .req_lvl(req_lvl), .free_lvl(free_lvl), .busy_lvl(busy_lvl),
        .boost_lvl(boost_lvl), .mst_req(mst_req), .addr_phase_free(free), .owner_busy(busy),
        .xfer_done(done), .dma_boost_req(boost));
    fba_arbiter dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .mst_req(mst_req),
        .addr_phase_free(free), .owner_busy(busy), .xfer_done(done), .dma_boost_req(boost),
        .arb_ptr(ptr), .bus_owner(owner), .starve_active(starve));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic conclude();
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // a hang ends here; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one classic wishbone cycle; data is taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, s, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        wb(1'b0, a, 4'hF, 32'h0000_0000, r);
        chk(nm, r, exp);
    endtask : rd

    // master levels change right after an edge
    task automatic set_in(input logic [3:0] r, input logic b, input logic bst);
        @(posedge clk);
        req_lvl <= r;
        busy_lvl <= b;
        boost_lvl <= bst;
    endtask : set_in

    // let n edges land, then look at settled outputs
    task automatic wait_chk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_chk

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs();
        rd(fba_pkg::ADR_CTL, fba_pkg::CTL_RESET, "ctl_reset");
        rd(8'h08, 32'h0000_0000, "unmapped");
        wr(fba_pkg::ADR_STAT, 4'hF, 32'hFFFF_FFFF);
        rd(fba_pkg::ADR_STAT, 32'h0000_0000, "stat_ro");
        wr(fba_pkg::ADR_CTL, 4'hF, 32'hFFFF_FFFF);
        rd(fba_pkg::ADR_CTL, 32'h02FF_7F00, "ctl_mask");
        // all priorities equal: default order, parked on master three
        rd(fba_pkg::ADR_STAT, 32'h0000_0053, "stat_dup");
        wr(fba_pkg::ADR_CTL, 4'h4, 32'h0000_0000);
        rd(fba_pkg::ADR_CTL, 32'h0200_7F00, "ctl_sel");
        wr(fba_pkg::ADR_CTL, 4'hF, fba_pkg::CTL_RESET);
    endtask : t_regs

    task automatic t_rotate();
        set_in(4'b0100, 1'b0, 1'b0);
        wait_chk(1);
        chk("ptr_move", ptr, 2'd2);
        chk("own_wait", owner, 2'd0);
        wait_chk(1);
        chk("own_now", owner, 2'd2);
        set_in(4'b1011, 1'b0, 1'b0);
        wait_chk(1);
        // owner two: three ranks 1, one ranks 3, zero ranks 2
        chk("ptr_rot", ptr, 2'd1);
        wait_chk(1);
        chk("own_rot", owner, 2'd1);
        chk("ptr_excl", ptr, 2'd0);
    endtask : t_rotate

    task automatic t_park();
        set_in(4'b0000, 1'b0, 1'b0);
        wait_chk(3);
        chk("park_last", ptr, 2'd0);
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h00E1_1000);
        wait_chk(2);
        chk("park_top", ptr, 2'd3);
    endtask : t_park

    task automatic t_fixed();
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h00E1_5000);
        set_in(4'b0010, 1'b0, 1'b0);
        wait_chk(1);
        chk("fix_pick", ptr, 2'd1);
        wait_chk(1);
        chk("fix_own", owner, 2'd1);
        set_in(4'b1010, 1'b1, 1'b0);
        wait_chk(2);
        chk("fix_hold", ptr, 2'd1);
        set_in(4'b1010, 1'b0, 1'b0);
        wait_chk(1);
        chk("fix_free", ptr, 2'd3);
    endtask : t_fixed

    task automatic t_starve();
        int n;
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h00E1_3000);
        set_in(4'b1010, 1'b1, 1'b0);
        wait_chk(8);
        chk("rot_nolock", starve, 1'b0);
        // limit of four denied cycles
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h00E1_7200);
        wait_chk(2);
        chk("lock_early", starve, 1'b0);
        n = 0;
        while (starve !== 1'b1 && n < 12) begin
            wait_chk(1);
            n++;
        end
        chk("lock_on", starve, 1'b1);
        set_in(4'b0000, 1'b0, 1'b0);
        n = 0;
        while (starve !== 1'b0 && n < 12) begin
            wait_chk(1);
            n++;
        end
        chk("lock_off", starve, 1'b0);
    endtask : t_starve

    // dma ranked lowest so only the boost can lift it over master zero
    task automatic t_boost();
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h02C9_5000);
        wait_chk(3);
        set_in(4'b0101, 1'b0, 1'b1);
        wait_chk(1);
        chk("boost_on", ptr, 2'd2);
        set_in(4'b0000, 1'b0, 1'b0);
        wr(fba_pkg::ADR_CTL, 4'hF, 32'h00C9_5000);
        wait_chk(3);
        set_in(4'b0101, 1'b0, 1'b1);
        wait_chk(1);
        chk("boost_off", ptr, 2'd0);
        set_in(4'b0000, 1'b0, 1'b0);
    endtask : t_boost

    // address phase blocked, then the finished owner yields to the dma master
    task automatic t_drop();
        wr(fba_pkg::ADR_CTL, 4'hF, fba_pkg::CTL_RESET);
        set_in(4'b1000, 1'b0, 1'b0);
        wait_chk(2);
        chk("drop_own", owner, 2'd3);
        @(posedge clk);
        free_lvl <= 1'b0;
        req_lvl <= 4'b1100;
        busy_lvl <= 1'b1;
        wait_chk(1);
        // owner three outranks two by rotation, but nobody gets the bus
        chk("nofree_ptr", ptr, 2'd3);
        chk("nofree_own", owner, 2'd3);
        set_in(4'b1100, 1'b0, 1'b0);
        wait_chk(2);
        chk("drop_ptr", ptr, 2'd2);
        set_in(4'b0000, 1'b0, 1'b0);
        free_lvl <= 1'b1;
    endtask : t_drop

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_rotate();
        t_park();
        t_fixed();
        t_starve();
        t_boost();
        t_drop();
        conclude();
    end
endmodule : fba_arbiter_bench
`default_nettype wire
